/* File: verilog/adcs_pkg.sv */
// constants shared by the converter control sequencer files
package adcs_pkg;
   // ----------------------------------------------------------------
   // register map: printed offsets are indices, byte address = 4*index
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 12;
   localparam logic [9:0]  IDX_RES_HIGH   = 10'h01e;
   localparam logic [9:0]  IDX_CONV_CTL   = 10'h01f;
   localparam logic [9:0]  IDX_RES_LOW    = 10'h09e;
   localparam logic [9:0]  IDX_PIN_CLK    = 10'h09f;
   localparam logic [9:0]  IDX_DONE_STAT  = 10'h020;
   // ----------------------------------------------------------------
   // converter_control fields
   // ----------------------------------------------------------------
   localparam int          CTL_JUSTIFY    = 7;
   localparam int          CTL_REF        = 6;
   localparam int          CTL_CHAN_LO    = 2;
   localparam int          CTL_GO         = 1;
   localparam int          CTL_ON         = 0;
   localparam logic [7:0]  CTL_WMASK      = 8'hcd;
   localparam logic [7:0]  CTL_RESET      = 8'h00;
   // ----------------------------------------------------------------
   // analog_pin_and_clock_select fields
   // ----------------------------------------------------------------
   localparam int          ANS_CLK_LO     = 4;
   localparam logic [7:0]  ANS_WMASK      = 8'h7f;
   localparam logic [7:0]  ANS_RESET      = 8'h0f;
   localparam logic [1:0]  CLK_RC_CODE    = 2'b11;
   // ----------------------------------------------------------------
   // done status register fields
   // ----------------------------------------------------------------
   localparam int          STAT_FLAG      = 0;
   localparam int          STAT_IRQ_EN    = 1;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          SYS_CLK_HZ     = 20_000_000;
   localparam int          RC_CLK_HZ      = 500_000;
   localparam int          RC_DIV         = (SYS_CLK_HZ + RC_CLK_HZ - 1) / RC_CLK_HZ;
   localparam int          INSTR_CYCLES   = 4;
   localparam int          CONV_TADS      = 11;
   localparam int          ABORT_TADS     = 2;
   localparam int          RESULT_W       = 10;

   typedef enum {
      ADCS_IDLE,
      ADCS_RC_WAIT,
      ADCS_CONVERT,
      ADCS_ABORT_WAIT
   } adcs_state_t;
endpackage : adcs_pkg

/* File: verilog/adcs_tad_gen.sv */
// conversion clock period tick generator
`timescale 1ns/100ps
module adcs_tad_gen
   import adcs_pkg::*;
#(
   parameter int RC_CYCLES = RC_DIV
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // control
   input  wire logic       restart,
   input  wire logic [2:0] clk_sel,
   // tick
   output logic            tick
);
   if (RC_CYCLES < 2 || RC_CYCLES > 256) begin : g_rc_range_bad
      $error("rc divider out of range");
   end

   logic [7:0] cnt_reg;
   logic       tick_reg;
   wire  [7:0] div_w;
   wire        wrap_w;

   // system clock ratios; x11 falls to the internal rc period
   assign div_w  = (clk_sel == 3'b000) ? 8'd2  :
                   (clk_sel == 3'b100) ? 8'd4  :
                   (clk_sel == 3'b001) ? 8'd8  :
                   (clk_sel == 3'b101) ? 8'd16 :
                   (clk_sel == 3'b010) ? 8'd32 :
                   (clk_sel == 3'b110) ? 8'd64 : 8'(RC_CYCLES - 1) + 8'd1;
   assign wrap_w = (cnt_reg == div_w - 8'd1);
   assign tick   = tick_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= (restart || wrap_w) ? 8'h00 : cnt_reg + 8'd1;
         tick_reg <= !restart && wrap_w;
      end
   end
endmodule : adcs_tad_gen

/* File: verilog/adcs_sar.sv */
// successive approximation register stepped once per conversion clock period
`timescale 1ns/100ps
module adcs_sar
   import adcs_pkg::*;
(
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   // control
   input  wire logic                start,
   input  wire logic                abort,
   input  wire logic                tick,
   input  wire logic                cmp_in,
   // status
   output logic [RESULT_W-1:0]      trial,
   output logic                     done
);
   logic [RESULT_W-1:0] trial_reg;
   logic [RESULT_W-1:0] bit_reg;
   logic                busy_reg;
   logic                setup_reg;
   logic                done_reg;
   logic [3:0]          tad_seen_reg;

   assign trial = trial_reg;
   assign done  = done_reg;

   // first period isolates the hold capacitor, then one bit per period
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trial_reg <= '0;
         bit_reg   <= '0;
         busy_reg  <= 1'b0;
         setup_reg <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            trial_reg <= {1'b1, {(RESULT_W-1){1'b0}}};
            bit_reg   <= {1'b1, {(RESULT_W-1){1'b0}}};
            busy_reg  <= 1'b1;
            setup_reg <= 1'b1;
         end else if (abort) begin
            busy_reg <= 1'b0;
         end else if (busy_reg && tick) begin
            setup_reg <= 1'b0;
            if (!setup_reg) begin
               trial_reg <= (cmp_in ? trial_reg : trial_reg & ~bit_reg) | (bit_reg >> 1);
               bit_reg   <= bit_reg >> 1;
               if (bit_reg[0]) begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
               end
            end
         end
      end
   end

   // helper count of periods since start, read only by the check below
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) tad_seen_reg <= 4'h0;
      else if (start) tad_seen_reg <= 4'h0;
      else if (tick && busy_reg) tad_seen_reg <= tad_seen_reg + 4'h1;
   end

   a_eleven_periods: assert property (@(posedge sys_clk) disable iff (!rst_b)
      done_reg |-> tad_seen_reg == 4'(CONV_TADS)) else $error("conversion length wrong");
endmodule : adcs_sar

/* File: verilog/adcs_ctrl.sv */
// converter control sequencer: apb registers, start/abort/sleep sequencing
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module adcs_ctrl
   import adcs_pkg::*;
#(
   parameter int RC_CYCLES = RC_DIV
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // core state
   input  wire logic              sleep_in,
   output logic                   conv_irq,
   output logic                   wake_req,
   // analog front end
   input  wire logic              cmp_in,
   output logic [RESULT_W-1:0]    sar_trial,
   output logic                   conv_power,
   output logic                   ref_external,
   output logic [1:0]             channel_select,
   output logic                   hold_sample,
   // pin control
   output logic [3:0]             analog_pin_select,
   output logic [3:0]             digital_in_off,
   output logic [3:0]             pullup_off,
   output logic [3:0]             change_irq_off
);
   if (RC_CYCLES < 2 || RC_CYCLES > 256) begin : g_rc_range_bad
      $error("rc divider out of range");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adcs_state_t state_reg;
   adcs_state_t state_next;
   logic [7:0]  ctl_reg;
   logic [7:0]  ans_reg;
   logic [7:0]  res_high_reg;
   logic [7:0]  res_low_reg;
   logic        flag_reg;
   logic        irq_en_reg;
   logic        pd_reg;
   logic [2:0]  wait_cnt_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        wake_reg;
   logic        power_reg;
   logic        ref_reg;
   logic [1:0]  chan_reg;
   logic        sample_reg;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire hit_res_high = (paddr == {IDX_RES_HIGH, 2'b00});
   wire hit_ctl      = (paddr == {IDX_CONV_CTL, 2'b00});
   wire hit_res_low  = (paddr == {IDX_RES_LOW, 2'b00});
   wire hit_ans      = (paddr == {IDX_PIN_CLK, 2'b00});
   wire hit_stat     = (paddr == {IDX_DONE_STAT, 2'b00});
   wire hit_any      = hit_res_high | hit_ctl | hit_res_low | hit_ans | hit_stat;
   // one wait state: data is captured, then pready rises
   wire acc_first    = psel && penable && !pready_reg;
   wire wr_commit    = psel && penable && pwrite && pready_reg;
   wire wr_ctl       = wr_commit && hit_ctl;
   wire wr_ans       = wr_commit && hit_ans;
   wire wr_stat      = wr_commit && hit_stat;

   // ----------------------------------------------------------------
   // sequencing terms
   // ----------------------------------------------------------------
   wire       rc_sel     = (ans_reg[ANS_CLK_LO+:2] == CLK_RC_CODE);
   wire       busy       = (state_reg == ADCS_RC_WAIT) || (state_reg == ADCS_CONVERT);
   wire       on_after   = wr_ctl ? pwdata[CTL_ON] : ctl_reg[CTL_ON];
   wire       go_req     = wr_ctl && pwdata[CTL_GO] && pwdata[CTL_ON] && ctl_reg[CTL_ON];
   wire       go_clear   = wr_ctl && !pwdata[CTL_GO] && busy;
   wire       sleep_kill = sleep_in && !rc_sel && busy;
   wire       tad_tick;
   wire       sar_done;
   wire       conv_start;
   wire       tad_restart;
   wire       rc_wait_end = (state_reg == ADCS_RC_WAIT) && (wait_cnt_reg == 3'(INSTR_CYCLES - 1));
   wire       done_ok     = sar_done && state_reg == ADCS_CONVERT && state_next == ADCS_IDLE
                            && on_after && !sleep_kill && !go_clear;
   wire [9:0] sar_value;
   wire [7:0] high_w;
   wire [7:0] low_w;
   wire [7:0] ctl_rd;
   wire [7:0] rd_byte;

   // start only when the machine really enters conversion, so an abort never leaves the sar running
   assign conv_start  = (state_reg != ADCS_CONVERT) && (state_next == ADCS_CONVERT);
   assign tad_restart = conv_start || go_clear;

   // ----------------------------------------------------------------
   // control state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ADCS_IDLE: begin
            if (go_req && rc_sel) state_next = ADCS_RC_WAIT;
            else if (go_req && !sleep_in) state_next = ADCS_CONVERT;
         end
         ADCS_RC_WAIT: begin
            if (rc_rwait_abort()) state_next = ADCS_IDLE;
            else if (go_clear) state_next = ADCS_ABORT_WAIT;
            else if (rc_wait_end) state_next = ADCS_CONVERT;
         end
         ADCS_CONVERT: begin
            if (!on_after || sleep_kill) state_next = ADCS_IDLE;
            else if (go_clear) state_next = ADCS_ABORT_WAIT;
            else if (sar_done) state_next = ADCS_IDLE;
         end
         ADCS_ABORT_WAIT: begin
            if (!on_after) state_next = ADCS_IDLE;
            else if (tad_tick && wait_cnt_reg == 3'(ABORT_TADS - 1)) state_next = ADCS_IDLE;
         end
         default: state_next = ADCS_IDLE;
      endcase
   end

   function automatic logic rc_rwait_abort();
      rc_rwait_abort = !on_after || sleep_kill;
   endfunction : rc_rwait_abort

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) state_reg <= ADCS_IDLE;
      else state_reg <= state_next;
   end

   // instruction delay in rc mode, period count in abort wait
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_cnt_reg <= 3'h0;
      end else if (state_next != state_reg) begin
         wait_cnt_reg <= 3'h0;
      end else if (state_reg == ADCS_RC_WAIT || (state_reg == ADCS_ABORT_WAIT && tad_tick)) begin
         wait_cnt_reg <= wait_cnt_reg + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // converter clock and sar
   // ----------------------------------------------------------------
   adcs_tad_gen #(.RC_CYCLES(RC_CYCLES)) u_tad (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .restart (tad_restart),
      .clk_sel (ans_reg[ANS_CLK_LO+:3]),
      .tick    (tad_tick)
   );

   adcs_sar u_sar (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .start   (conv_start),
      .abort   (state_reg == ADCS_CONVERT && state_next != ADCS_CONVERT && !sar_done),
      .tick    (tad_tick),
      .cmp_in  (cmp_in),
      .trial   (sar_value),
      .done    (sar_done)
   );

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_reg    <= CTL_RESET;
         ans_reg    <= ANS_RESET;
         irq_en_reg <= 1'b0;
      end else begin
         if (wr_ctl) ctl_reg <= pwdata[7:0] & CTL_WMASK;
         if (wr_ans) ans_reg <= pwdata[7:0] & ANS_WMASK;
         if (wr_stat) irq_en_reg <= pwdata[STAT_IRQ_EN];
      end
   end

   // completion flag: a completion in the clearing cycle wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) flag_reg <= 1'b0;
      else flag_reg <= (flag_reg && !(wr_stat && pwdata[STAT_FLAG])) || done_ok;
   end

   // ----------------------------------------------------------------
   // result bytes: no reset, they survive a device reset
   // ----------------------------------------------------------------
   assign high_w = ctl_reg[CTL_JUSTIFY] ? {6'h00, sar_value[9:8]} : sar_value[9:2];
   assign low_w  = ctl_reg[CTL_JUSTIFY] ? sar_value[7:0] : {sar_value[1:0], 6'h00};

   always_ff @(posedge sys_clk) begin
      if (done_ok) begin
         res_high_reg <= high_w;
         res_low_reg  <= low_w;
      end
   end

   // ----------------------------------------------------------------
   // power down after sleep; cleared on wake or when switched off
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) pd_reg <= 1'b0;
      else if (!sleep_in || !on_after) pd_reg <= 1'b0;
      else if (sleep_kill) pd_reg <= 1'b1;
      else if (done_ok && !irq_en_reg) pd_reg <= 1'b1;
   end

   // ----------------------------------------------------------------
   // readback
   // ----------------------------------------------------------------
   assign ctl_rd  = {ctl_reg[7:6], 2'b00, ctl_reg[3:2], busy, ctl_reg[CTL_ON]};
   assign rd_byte = hit_ctl      ? ctl_rd :
                    hit_ans      ? ans_reg :
                    hit_res_high ? res_high_reg :
                    hit_res_low  ? res_low_reg :
                    hit_stat     ? {6'h00, irq_en_reg, flag_reg} : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= acc_first;
         pslverr_reg <= acc_first && !hit_any;
         if (acc_first) prdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // front end and pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg    <= 1'b0;
         wake_reg   <= 1'b0;
         power_reg  <= 1'b0;
         ref_reg    <= 1'b0;
         chan_reg   <= 2'b00;
         sample_reg <= 1'b0;
      end else begin
         irq_reg    <= flag_reg && irq_en_reg;
         wake_reg   <= sleep_in && flag_reg && irq_en_reg;
         power_reg  <= ctl_reg[CTL_ON] && !pd_reg;
         ref_reg    <= ctl_reg[CTL_REF];
         chan_reg   <= ctl_reg[CTL_CHAN_LO+:2];
         // capacitor only tracks the input, it is never discharged
         sample_reg <= ctl_reg[CTL_ON] && !pd_reg && state_reg == ADCS_IDLE;
      end
   end

   assign prdata            = prdata_reg;
   assign pready            = pready_reg;
   assign pslverr           = pslverr_reg;
   assign conv_irq          = irq_reg;
   assign wake_req          = wake_reg;
   assign sar_trial         = sar_value;
   assign conv_power        = power_reg;
   assign ref_external      = ref_reg;
   assign channel_select    = chan_reg;
   assign hold_sample       = sample_reg;
   assign analog_pin_select = ans_reg[3:0];
   assign digital_in_off    = ans_reg[3:0];
   assign pullup_off        = ans_reg[3:0];
   assign change_irq_off    = ans_reg[3:0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_off_no_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !ctl_reg[CTL_ON] |-> ##1 !(state_reg == ADCS_CONVERT && $past(state_reg) == ADCS_IDLE))
      else $error("conversion started while off");

   a_rc_delay: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_reg == ADCS_IDLE && go_req && rc_sel) |=> state_reg == ADCS_RC_WAIT ##4 state_reg != ADCS_RC_WAIT)
      else $error("rc start delay wrong");

   a_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
      done_ok |=> flag_reg && !busy) else $error("completion not flagged");

   a_abort_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (busy && go_clear && on_after && !sleep_kill) |=> $stable(res_high_reg) && $stable(res_low_reg)
      && state_reg == ADCS_ABORT_WAIT)
      else $error("abort disturbed result");

   a_sleep_abort: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (sleep_kill && on_after) |=> state_reg == ADCS_IDLE && pd_reg && ctl_reg[CTL_ON])
      else $error("sleep abort wrong");

   a_right_just: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (done_ok && ctl_reg[CTL_JUSTIFY]) |=> res_high_reg[7:2] == 6'h00 && res_low_reg == $past(sar_value[7:0]))
      else $error("right justified result wrong");

   a_power_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !ctl_reg[CTL_ON] |=> !conv_power) else $error("converter powered while off");

   a_off_abort: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_reg != ADCS_IDLE && !on_after) |=> state_reg == ADCS_IDLE)
      else $error("switch off did not stop the converter");

   a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      conv_irq |-> $past(flag_reg) && $past(irq_en_reg)) else $error("irq without flag and enable");

   a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctl_reg[5:4] == 2'b00 && ans_reg[7] == 1'b0) else $error("unimplemented bit set");
endmodule : adcs_ctrl

/* File: testbench/adcs_afe_model.sv */
// analog mux, sample-and-hold and comparator model
`timescale 1ns/100ps
module adcs_afe_model
   import adcs_pkg::*;
#(
   parameter logic [79:0] LEVELS = '0
) (
   // clock
   input  wire logic                sys_clk,
   // converter side
   input  wire logic [RESULT_W-1:0] sar_trial,
   input  wire logic                conv_power,
   input  wire logic                ref_external,
   input  wire logic [1:0]          channel_select,
   input  wire logic                hold_sample,
   // comparator
   output logic                     cmp_in
);
   logic [RESULT_W-1:0] held_reg;
   logic                junk_reg = 1'b0;
   wire  [2:0]          pick = {ref_external, channel_select};
   always_ff @(posedge sys_clk) begin
      junk_reg <= ~junk_reg;
      if (hold_sample) held_reg <= LEVELS[pick*10 +: 10];
   end
   // an unpowered comparator must not look like a valid answer
   assign cmp_in = conv_power ? (held_reg >= sar_trial) : junk_reg;
endmodule : adcs_afe_model

/* File: testbench/tb_adcs_ctrl.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/100ps
module tb_adcs_ctrl
   import adcs_pkg::*;
;
   localparam logic [79:0] LEVELS = {10'h3c3, 10'h155, 10'h2aa, 10'h001, 10'h0f0, 10'h200, 10'h17e, 10'h30c};
   localparam logic [11:0] A_HI = {IDX_RES_HIGH, 2'b00}, A_CTL = {IDX_CONV_CTL, 2'b00};
   localparam logic [11:0] A_LO = {IDX_RES_LOW, 2'b00}, A_ANS = {IDX_PIN_CLK, 2'b00}, A_ST = {IDX_DONE_STAT, 2'b00};
   localparam int          RCC = 4;
   localparam logic [2:0]  CODES [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   localparam int          DIVS [8] = '{2, 4, 8, 16, 32, 64, RCC, RCC};
   logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, sleep_in, e;
   logic        conv_irq, wake_req, cmp_in, conv_power, ref_external, hold_sample;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [9:0]  sar_trial, lv;
   logic [1:0]  channel_select;
   logic [3:0]  analog_pin_select, digital_in_off, pullup_off, change_irq_off;
   int          err_count = 0, samples_checked = 0, cyc = 0, t0, el, dur;

   adcs_ctrl #(.RC_CYCLES(RCC)) i_adcs_ctrl (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleep_in, .conv_irq, .wake_req, .cmp_in, .sar_trial, .conv_power,
      .ref_external, .channel_select, .hold_sample, .analog_pin_select, .digital_in_off, .pullup_off,
      .change_irq_off);
   adcs_afe_model #(.LEVELS(LEVELS)) i_adcs_afe_model (.sys_clk, .sar_trial, .conv_power, .ref_external,
      .channel_select, .hold_sample, .cmp_in);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in the same step
      @(posedge sys_clk);
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk(q, {24'h0, x});
   endtask : rdc
   task automatic close_out;
      if (err_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      close_out();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, psel, penable, pwrite, sleep_in} = '0;
      paddr = '0;
      pwdata = '0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdc(A_CTL, 8'h00);
      rdc(A_ANS, 8'h0f);
      chk({analog_pin_select, digital_in_off, pullup_off, change_irq_off}, 16'hffff);
      apb(1'b1, A_CTL, 8'hff);
      rdc(A_CTL, 8'hcd);
      apb(1'b1, A_CTL, 8'h00);
      apb(1'b1, 12'h004, 8'h5a);
      chk(e, 1'b1);
      apb(1'b0, 12'h004, 8'h00);
      chk({e, q[30:0]}, 32'h80000000);
      chk(conv_power, 1'b0);
      apb(1'b1, A_ST, 8'h02);
      for (int i = 0; i < 8; i++) begin
         lv = LEVELS[i*10 +: 10];
         apb(1'b1, A_ANS, {1'b1, CODES[i], 4'(i + 6)});
         rdc(A_ANS, {1'b0, CODES[i], 4'(i + 6)});
         chk({analog_pin_select, digital_in_off, pullup_off, change_irq_off}, {4{4'(i + 6)}});
         apb(1'b1, A_CTL, {i[0], i[2], 2'b11, i[1:0], 2'b01});
         repeat (8) @(posedge sys_clk);
         chk({channel_select, ref_external, conv_power}, {i[1:0], i[2], 1'b1});
         apb(1'b1, A_CTL, {i[0], i[2], 2'b00, i[1:0], 2'b11});
         t0 = cyc;
         rdc(A_CTL, {i[0], i[2], 2'b00, i[1:0], 2'b11});
         for (int n = 0; n < 300 && q[1] !== 1'b0; n++) apb(1'b0, A_CTL, 8'h00);
         dur = 11 * DIVS[i] + (i > 5 ? INSTR_CYCLES : 0);
         el = cyc - t0;
         chk(el >= dur - 2 && el <= dur + 14, 1'b1);
         rdc(A_HI, i[0] ? {6'h00, lv[9:8]} : lv[9:2]);
         rdc(A_LO, i[0] ? lv[7:0] : {lv[1:0], 6'h00});
         rdc(A_ST, 8'h03);
         chk(conv_irq, 1'b1);
         apb(1'b1, A_ST, 8'h03);
      end
      // abort by clearing go on the slowest divider
      apb(1'b1, A_ANS, 8'h6f);
      apb(1'b1, A_CTL, 8'h03);
      repeat (100) @(posedge sys_clk);
      apb(1'b1, A_CTL, 8'h01);
      rdc(A_CTL, 8'h01);
      chk(hold_sample, 1'b0);
      repeat (150) @(posedge sys_clk);
      chk(hold_sample, 1'b1);
      rdc(A_HI, {6'h00, lv[9:8]});
      rdc(A_ST, 8'h02);
      apb(1'b1, A_CTL, 8'h03);
      repeat (50) @(posedge sys_clk);
      sleep_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk({conv_power, hold_sample}, 2'b00);
      rdc(A_CTL, 8'h01);
      rdc(A_HI, {6'h00, lv[9:8]});
      sleep_in <= 1'b0;
      apb(1'b1, A_ST, 8'h01);
      apb(1'b1, A_ANS, 8'h30);
      lv = LEVELS[9:0];
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, A_CTL, 8'h03);
         sleep_in <= 1'b1;
         repeat (70) @(posedge sys_clk);
         chk({wake_req, conv_power}, {k[0], k[0]});
         rdc(A_CTL, 8'h01);
         rdc(A_HI, lv[9:2]);
         sleep_in <= 1'b0;
         apb(1'b1, A_ST, 8'h03);
      end
      apb(1'b1, A_ANS, 8'h6f);
      apb(1'b1, A_CTL, 8'h03);
      apb(1'b1, A_CTL, 8'h00);
      rdc(A_CTL, 8'h00);
      chk(conv_power, 1'b0);
      rdc(A_HI, lv[9:2]);
      apb(1'b1, A_CTL, 8'h01);
      apb(1'b1, A_CTL, 8'h83);
      repeat (30) @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      chk(conv_power, 1'b0);
      rdc(A_CTL, 8'h00);
      rdc(A_ANS, 8'h0f);
      rdc(A_HI, lv[9:2]);
      rdc(A_LO, {lv[1:0], 6'h00});
      close_out();
   end
endmodule : tb_adcs_ctrl
